//--- common/cbs_defines.svh
`ifndef CBS_DEFINES_SVH
`define CBS_DEFINES_SVH

// ----------------------------------------
// Family densities in bits
// ----------------------------------------
`define CBS_DENS_1MB      1048576
`define CBS_DENS_8MB      8388608
`define CBS_DENS_32MB     33554432

// ----------------------------------------
// Timing
// ----------------------------------------
`define CBS_CORE_NS       50
`define CBS_FMAX_MHZ      33
`define CBS_ICLK_NS       200
`define CBS_ICLK_HALF     ((`CBS_ICLK_NS + 2 * `CBS_CORE_NS - 1) / (2 * `CBS_CORE_NS))

// ----------------------------------------
// Revisions and stream format
// ----------------------------------------
`define CBS_REV_W         2
`define CBS_REV_SH        2
`define CBS_BYTE_MSB      3'h7
`define CBS_RLE_ESC       8'hA5
`define CBS_RLE_LIT       8'h00
`define CBS_RLE_LAST      8'h01

`endif

//--- common/cbs_pkg.sv
package cbs_pkg;

    // Pins that arrive from the board, synchronised as one word
    typedef struct packed {
        logic       chip_en_b;
        logic       oe_reset;
        logic       config_trigger_in;
        logic       busy;
        logic       config_clock;
        logic       ext_sel_en;
        logic [1:0] rev_sel;
        logic       byte_mode;
        logic       clk_internal;
    } cbs_pin_in_t;

    typedef enum logic [1:0] {
        CBS_IDLE,
        CBS_RUN,
        CBS_DONE,
        CBS_PROG
    } cbs_state_t;

    typedef enum logic [1:0] {
        CBS_D_LIT,
        CBS_D_CNT,
        CBS_D_VAL,
        CBS_D_RUN
    } cbs_dec_state_t;

endpackage : cbs_pkg

//--- core/cbs_decomp.sv
`timescale 1ns/1ns
`include "cbs_defines.svh"

module cbs_decomp (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Control
    input  wire logic       clear,
    input  wire logic       bypass,
    // Compressed bytes in
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output      logic       in_ready,
    // Expanded bytes out
    output      logic       out_valid,
    output      logic [7:0] out_data,
    input  wire logic       out_ready,
    output      logic       empty
);

    cbs_pkg::cbs_dec_state_t st_r, st_nxt;
    logic [7:0]              cnt_r, cnt_nxt;
    logic [7:0]              val_r, val_nxt;
    logic                    ov_r, ov_nxt;
    logic [7:0]              od_r, od_nxt;
    logic                    space;

    assign space     = !ov_r || out_ready;
    assign in_ready  = space && (st_r != cbs_pkg::CBS_D_RUN) && !clear;
    assign out_valid = ov_r;
    assign out_data  = od_r;
    assign empty     = (st_r == cbs_pkg::CBS_D_LIT) && !ov_r;

    // ----------------------------------------
    // Run-length expansion
    // ----------------------------------------
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        val_nxt = val_r;
        ov_nxt  = ov_r && !out_ready;
        od_nxt  = od_r;
        if (clear) begin
            st_nxt = cbs_pkg::CBS_D_LIT;
            ov_nxt = 1'b0;
        end else if (space) begin
            case (st_r)
                cbs_pkg::CBS_D_RUN: begin
                    ov_nxt  = 1'b1;
                    od_nxt  = val_r;
                    cnt_nxt = cnt_r - `CBS_RLE_LAST;
                    if (cnt_r == `CBS_RLE_LAST) begin
                        st_nxt = cbs_pkg::CBS_D_LIT;
                    end
                end
                cbs_pkg::CBS_D_LIT: begin
                    if (in_valid) begin
                        if (bypass || in_data != `CBS_RLE_ESC) begin
                            ov_nxt = 1'b1;
                            od_nxt = in_data;
                        end else begin
                            st_nxt = cbs_pkg::CBS_D_CNT;
                        end
                    end
                end
                cbs_pkg::CBS_D_CNT: begin
                    if (in_valid) begin
                        // Zero count escapes the marker byte itself
                        if (in_data == `CBS_RLE_LIT) begin
                            ov_nxt = 1'b1;
                            od_nxt = `CBS_RLE_ESC;
                            st_nxt = cbs_pkg::CBS_D_LIT;
                        end else begin
                            cnt_nxt = in_data;
                            st_nxt  = cbs_pkg::CBS_D_VAL;
                        end
                    end
                end
                cbs_pkg::CBS_D_VAL: begin
                    if (in_valid) begin
                        val_nxt = in_data;
                        st_nxt  = cbs_pkg::CBS_D_RUN;
                    end
                end
                default: begin
                    st_nxt = cbs_pkg::CBS_D_LIT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r  <= cbs_pkg::CBS_D_LIT;
            cnt_r <= 8'h00;
            val_r <= 8'h00;
            ov_r  <= 1'b0;
            od_r  <= 8'h00;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            val_r <= val_nxt;
            ov_r  <= ov_nxt;
            od_r  <= od_nxt;
        end
    end

endmodule : cbs_decomp

//--- core/cbs_top.sv
`timescale 1ns/1ns
`include "cbs_defines.svh"


module cbs_top #(
    parameter int DENSITY_BITS = `CBS_DENS_32MB,
    parameter bit PARALLEL     = 1'b1,
    parameter bit CASCADED     = 1'b0,
    parameter bit COMPRESS     = 1'b1
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // Board pins
    input  wire cbs_pkg::cbs_pin_in_t pins_in,
    // Programming port
    input  wire logic               prog_active,
    input  wire logic               prog_we,
    input  wire logic [31:0]        prog_addr,
    input  wire logic [7:0]         prog_data,
    input  wire logic               prog_rev_we,
    // Data pins
    output      logic               serial_bit_out,
    output      logic               serial_oe_b,
    output      logic [7:0]         byte_lanes_out,
    output      logic               byte_oe_b,
    // Generated configuration clock
    output      logic               config_clock_drv,
    output      logic               config_clock_oe_b,
    // Cascade
    output      logic               cascade_enable_out
);

    localparam int MEM_BYTES = DENSITY_BITS / 8;
    localparam int AW        = $clog2(MEM_BYTES);
    localparam bit REV_EN    = PARALLEL && !(DENSITY_BITS == `CBS_DENS_8MB && !CASCADED);
    localparam int REG_SH    = AW - `CBS_REV_SH;
    localparam logic [AW:0] REGION = (AW + 1)'(REV_EN ? (MEM_BYTES >> `CBS_REV_SH) : MEM_BYTES);
    localparam logic [7:0]  HALF   = 8'(`CBS_ICLK_HALF);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    cbs_pkg::cbs_pin_in_t s1_r, s2_r;
    logic                 config_clock_d_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r     <= '0;
            s2_r     <= '0;
            config_clock_d_r <= 1'b0;
        end else begin
            s1_r     <= pins_in;
            s2_r     <= s1_r;
            config_clock_d_r <= s2_r.config_clock;
        end
    end

    logic enabled;
    logic byte_md;
    logic int_clk;
    logic busy;
    logic ext_rise;

    assign enabled  = !s2_r.chip_en_b && s2_r.oe_reset && s2_r.config_trigger_in;
    assign byte_md  = PARALLEL && s2_r.byte_mode;
    // internal clock only on parallel variant
    assign int_clk  = PARALLEL && s2_r.clk_internal;
    assign busy     = s2_r.busy;
    // rising edge of FPGA or oscillator clock
    assign ext_rise = s2_r.config_clock && !config_clock_d_r;

    // ----------------------------------------
    // Image store
    // ----------------------------------------
    logic [7:0]  mem [MEM_BYTES];
    logic [7:0]  rd_data_r;
    logic        rd_go;
    logic [AW:0] addr_r, addr_nxt;

    always_ff @(posedge core_clk) begin
        if (prog_active && prog_we) begin
            mem[prog_addr[AW-1:0]] <= prog_data;
        end
        if (rd_go) begin
            rd_data_r <= mem[addr_r[AW-1:0]];
        end
    end

    // ----------------------------------------
    // Decompressor
    // ----------------------------------------
    cbs_pkg::cbs_state_t st_r, st_nxt;
    logic       dec_in_ready;
    logic       dec_out_valid;
    logic [7:0] dec_out_data;
    logic       dec_take;
    logic       dec_empty;
    logic       rd_vld_r, rd_vld_nxt;

    cbs_decomp u_decomp (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .clear     (st_r != cbs_pkg::CBS_RUN),
        .bypass    (!(PARALLEL && COMPRESS)),
        .in_valid  (rd_vld_r && st_r == cbs_pkg::CBS_RUN),
        .in_data   (rd_data_r),
        .in_ready  (dec_in_ready),
        .out_valid (dec_out_valid),
        .out_data  (dec_out_data),
        .out_ready (dec_take),
        .empty     (dec_empty)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [AW:0]           end_r, end_nxt;
    logic [`CBS_REV_W-1:0] rev_ctrl_r, rev_ctrl_nxt;
    logic [`CBS_REV_W-1:0] rev_pick;
    logic [AW:0]           base_c;
    logic [7:0]            cur_r, cur_nxt;
    logic                  cur_vld_r, cur_vld_nxt;
    logic [2:0]            bit_r, bit_nxt;
    logic [7:0]            div_r, div_nxt;
    logic                  iclk_r, iclk_nxt;
    logic                  iclk_oe_b_r, iclk_oe_b_nxt;
    logic                  ser_r, ser_nxt;
    logic                  ser_oe_b_r, ser_oe_b_nxt;
    logic [7:0]            lanes_r, lanes_nxt;
    logic                  lanes_oe_b_r, lanes_oe_b_nxt;
    logic                  ceo_r, ceo_nxt;
    logic                  tick;
    logic                  adv;
    logic                  need_new;
    logic                  src_empty;
    logic                  load_first;
    logic                  run_nxt;

    assign rev_pick  = s2_r.ext_sel_en ? s2_r.rev_sel : rev_ctrl_r;
    assign base_c    = REV_EN ? ((AW + 1)'(rev_pick) << REG_SH) : '0;
    assign rd_go     = (st_r == cbs_pkg::CBS_RUN) && (addr_r < end_r) && (!rd_vld_r || dec_in_ready);
    assign src_empty = (addr_r >= end_r) && !rd_vld_r && dec_empty;
    assign need_new  = byte_md || (bit_r == 3'h0);

    always_comb begin
        st_nxt        = st_r;
        addr_nxt      = addr_r;
        end_nxt       = end_r;
        rev_ctrl_nxt  = rev_ctrl_r;
        cur_nxt       = cur_r;
        cur_vld_nxt   = cur_vld_r;
        bit_nxt       = bit_r;
        div_nxt       = div_r;
        iclk_nxt      = iclk_r;
        dec_take      = 1'b0;
        tick          = 1'b0;
        adv           = 1'b0;
        load_first    = 1'b0;
        rd_vld_nxt    = rd_vld_r;

        if (prog_active && prog_rev_we) begin
            rev_ctrl_nxt = prog_data[`CBS_REV_W-1:0];
        end

        // divider drives the FPGA clock when asked
        if (st_r == cbs_pkg::CBS_RUN && int_clk) begin
            // held low until a byte stands, so no rise finds stale data
            if (!cur_vld_r && !iclk_r) begin
                div_nxt = 8'h00;
            end else if (div_r == HALF - 8'h01) begin
                div_nxt  = 8'h00;
                iclk_nxt = !iclk_r;
            end else begin
                div_nxt = div_r + 8'h01;
            end
            // step one core cycle after the rise, never on it
            tick = iclk_r && (div_r == 8'h00);
        end else begin
            div_nxt  = 8'h00;
            iclk_nxt = 1'b0;
            // external edges sampled on the core clock
            tick     = ext_rise;
        end

        if (rd_go) begin
            addr_nxt   = addr_r + (AW + 1)'(1);
            rd_vld_nxt = 1'b1;
        end else if (dec_in_ready) begin
            rd_vld_nxt = 1'b0;
        end

        case (st_r)
            cbs_pkg::CBS_IDLE: begin
                cur_vld_nxt = 1'b0;
                rd_vld_nxt  = 1'b0;
                if (enabled) begin
                    addr_nxt = base_c;
                    end_nxt  = base_c + REGION;
                    st_nxt   = cbs_pkg::CBS_RUN;
                end
            end
            cbs_pkg::CBS_RUN: begin
                // busy holds the byte in place in byte mode only
                adv        = tick && cur_vld_r && !(byte_md && busy);
                load_first = !cur_vld_r && dec_out_valid;
                if (load_first) begin
                    cur_nxt     = dec_out_data;
                    cur_vld_nxt = 1'b1;
                    bit_nxt     = `CBS_BYTE_MSB;
                    dec_take    = 1'b1;
                end else if (adv) begin
                    // step to next bit or byte
                    if (!need_new) begin
                        bit_nxt = bit_r - 3'h1;
                    end else if (dec_out_valid) begin
                        cur_nxt  = dec_out_data;
                        bit_nxt  = `CBS_BYTE_MSB;
                        dec_take = 1'b1;
                    end else if (src_empty) begin
                        st_nxt = cbs_pkg::CBS_DONE;
                    end else begin
                        cur_vld_nxt = 1'b0;
                    end
                end
                if (!enabled) begin
                    st_nxt = cbs_pkg::CBS_IDLE;
                end
            end
            cbs_pkg::CBS_DONE: begin
                cur_vld_nxt = 1'b0;
                if (!enabled) begin
                    st_nxt = cbs_pkg::CBS_IDLE;
                end
            end
            cbs_pkg::CBS_PROG: begin
                cur_vld_nxt = 1'b0;
                rd_vld_nxt  = 1'b0;
                if (!prog_active) begin
                    st_nxt = cbs_pkg::CBS_IDLE;
                end
            end
            default: begin
                st_nxt = cbs_pkg::CBS_IDLE;
            end
        endcase

        if (prog_active) begin
            st_nxt      = cbs_pkg::CBS_PROG;
            cur_vld_nxt = 1'b0;
        end

        run_nxt = (st_nxt == cbs_pkg::CBS_RUN) && cur_vld_nxt;
        ser_nxt        = cur_nxt[bit_nxt];
        lanes_nxt      = cur_nxt;
        ser_oe_b_nxt   = !(run_nxt && !byte_md);
        lanes_oe_b_nxt = !(run_nxt && byte_md && !busy);
        iclk_oe_b_nxt  = !(int_clk && st_nxt != cbs_pkg::CBS_PROG);
        ceo_nxt        = (st_nxt == cbs_pkg::CBS_DONE) || (st_nxt == cbs_pkg::CBS_PROG);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r         <= cbs_pkg::CBS_IDLE;
            addr_r       <= '0;
            end_r        <= '0;
            rev_ctrl_r   <= '0;
            cur_r        <= 8'h00;
            cur_vld_r    <= 1'b0;
            bit_r        <= 3'h0;
            div_r        <= 8'h00;
            iclk_r       <= 1'b0;
            iclk_oe_b_r  <= 1'b1;
            rd_vld_r     <= 1'b0;
            ser_r        <= 1'b0;
            ser_oe_b_r   <= 1'b1;
            lanes_r      <= 8'h00;
            lanes_oe_b_r <= 1'b1;
            ceo_r        <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            addr_r       <= addr_nxt;
            end_r        <= end_nxt;
            rev_ctrl_r   <= rev_ctrl_nxt;
            cur_r        <= cur_nxt;
            cur_vld_r    <= cur_vld_nxt;
            bit_r        <= bit_nxt;
            div_r        <= div_nxt;
            iclk_r       <= iclk_nxt;
            iclk_oe_b_r  <= iclk_oe_b_nxt;
            rd_vld_r     <= rd_vld_nxt;
            ser_r        <= ser_nxt;
            ser_oe_b_r   <= ser_oe_b_nxt;
            lanes_r      <= lanes_nxt;
            lanes_oe_b_r <= lanes_oe_b_nxt;
            ceo_r        <= ceo_nxt;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    assign serial_bit_out     = ser_r;
    assign serial_oe_b        = ser_oe_b_r;
    assign byte_lanes_out     = lanes_r;
    assign byte_oe_b          = lanes_oe_b_r;
    assign config_clock_drv   = iclk_r;
    assign config_clock_oe_b  = iclk_oe_b_r;
    assign cascade_enable_out = ceo_r;

endmodule : cbs_top

//--- tb/cbs_fpga_model.sv
`timescale 1ns/1ns

module cbs_fpga_model (
    // Clocks
    input  wire logic       core_clk,
    input  wire logic       cfg_clk_in,
    output      logic       cfg_clk_out,
    // Data and status
    input  wire logic [7:0] lanes_in,
    input  wire logic       bit_in,
    output      logic       busy_out
);
    logic [7:0] cap_q[$];
    logic       bit_q[$];

    initial begin
        cfg_clk_out = 1'b0;
        busy_out    = 1'b0;
    end

    // exact pulses, idle low between frames
    // Ten core cycles a period keeps the sampled clock well inside its limit
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (5) @(negedge core_clk);
            cfg_clk_out = 1'b1;
            repeat (5) @(negedge core_clk);
            cfg_clk_out = 1'b0;
        end
    endtask : pulses

    task automatic set_busy(input logic b);
        @(negedge core_clk);
        busy_out = b;
    endtask : set_busy

    // capture on the edge after the update
    always @(posedge cfg_clk_in) begin
        cap_q.push_back(lanes_in);
        bit_q.push_back(bit_in);
    end
endmodule : cbs_fpga_model

//--- tb/cbs_top_properties.sv
`timescale 1ns/1ns

module cbs_top_chk (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rst_b,
    // Watched ports
    input wire cbs_pkg::cbs_pin_in_t pins_in,
    input wire logic                 prog_active,
    input wire logic                 serial_bit_out,
    input wire logic                 serial_oe_b,
    input wire logic [7:0]           byte_lanes_out,
    input wire logic                 byte_oe_b,
    input wire logic                 config_clock_oe_b,
    input wire logic                 cascade_enable_out
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    property p_prog_park;
        prog_active |=> cascade_enable_out && serial_oe_b && byte_oe_b && config_clock_oe_b;
    endproperty
    a_prog_park: assert property (p_prog_park) else $error("outputs not parked in programming");

    // Sync delay plus state and output registers fit in five cycles
    property p_disable_float;
        (!prog_active && (pins_in.chip_en_b || !pins_in.oe_reset))[*5]
            |-> serial_oe_b && byte_oe_b && !cascade_enable_out;
    endproperty
    a_disable_float: assert property (p_disable_float) else $error("outputs driven while disabled");

    property p_busy_float;
        pins_in.busy[*5] |-> byte_oe_b;
    endproperty
    a_busy_float: assert property (p_busy_float) else $error("byte lanes driven under busy");

    property p_trigger_gate;
        (!pins_in.config_trigger_in)[*5] |-> serial_oe_b && byte_oe_b;
    endproperty
    a_trigger_gate: assert property (p_trigger_gate) else $error("data driven with trigger low");

    // A tick in flight lands within four cycles of the pin edge
    property p_byte_stands;
        (!byte_oe_b && $stable(pins_in.config_clock))[*6] |-> $stable(byte_lanes_out);
    endproperty
    a_byte_stands: assert property (p_byte_stands) else $error("byte changed without a tick");

    property p_bit_stands;
        (!serial_oe_b && $stable(pins_in.config_clock))[*6] |-> $stable(serial_bit_out);
    endproperty
    a_bit_stands: assert property (p_bit_stands) else $error("bit changed without a tick");

    property p_clock_drive;
        (!pins_in.clk_internal)[*5] |-> config_clock_oe_b;
    endproperty
    a_clock_drive: assert property (p_clock_drive) else $error("clock driven in external mode");

    property p_cascade_quiet;
        cascade_enable_out |-> serial_oe_b && byte_oe_b;
    endproperty
    a_cascade_quiet: assert property (p_cascade_quiet) else $error("cascade high while driving");
endmodule : cbs_top_chk

bind cbs_top cbs_top_chk i_cbs_top_chk (
    .core_clk(core_clk), .rst_b(rst_b), .pins_in(pins_in), .prog_active(prog_active),
    .serial_bit_out(serial_bit_out), .serial_oe_b(serial_oe_b), .byte_lanes_out(byte_lanes_out),
    .byte_oe_b(byte_oe_b), .config_clock_oe_b(config_clock_oe_b), .cascade_enable_out(cascade_enable_out)
);

//--- tb/cbs_top_tb.sv
`timescale 1ns/1ns
`include "cbs_defines.svh"

`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module cbs_top_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic                 core_clk, rst_b, ce_b, oe_rst, trig, ext_sel, byte_mode, clk_int;
    logic [1:0]           rev_sel;
    logic                 prog_active, prog_we, prog_rev_we;
    logic [31:0]          prog_addr;
    logic [7:0]           prog_data;
    logic                 serial_bit_out, serial_oe_b, byte_oe_b, config_clock_drv, config_clock_oe_b;
    logic                 cascade_enable_out, fpga_clk, fpga_busy, cfg_clk_w, bit_w, last_bit;
    logic [7:0]           byte_lanes_out, lanes_w, last_lanes;
    logic [7:0]           exp_b [5];
    cbs_pkg::cbs_pin_in_t pins;
    int                   n_mismatch, tests_run;

    always #25 core_clk = ~core_clk;

    assign cfg_clk_w = config_clock_oe_b ? fpga_clk : config_clock_drv;
    // Released lines show the inverse of the last driven value
    assign lanes_w   = byte_oe_b ? ~last_lanes : byte_lanes_out;
    assign bit_w     = serial_oe_b ? ~last_bit : serial_bit_out;
    assign pins      = {ce_b, oe_rst, trig, fpga_busy, cfg_clk_w, ext_sel, rev_sel, byte_mode, clk_int};

    always @(posedge core_clk) begin
        if (!byte_oe_b)
            last_lanes <= byte_lanes_out;
        if (!serial_oe_b)
            last_bit <= serial_bit_out;
    end

    cbs_top #(.DENSITY_BITS(`CBS_DENS_1MB)) i_cbs_top (
        .core_clk(core_clk), .rst_b(rst_b), .pins_in(pins), .prog_active(prog_active), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_data(prog_data), .prog_rev_we(prog_rev_we),
        .serial_bit_out(serial_bit_out), .serial_oe_b(serial_oe_b), .byte_lanes_out(byte_lanes_out),
        .byte_oe_b(byte_oe_b), .config_clock_drv(config_clock_drv), .config_clock_oe_b(config_clock_oe_b),
        .cascade_enable_out(cascade_enable_out)
    );

    cbs_fpga_model i_cbs_fpga_model (
        .core_clk(core_clk), .cfg_clk_in(cfg_clk_w), .cfg_clk_out(fpga_clk),
        .lanes_in(lanes_w), .bit_in(bit_w), .busy_out(fpga_busy)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic prog(input logic [31:0] a, input logic [7:0] d, input logic rev);
        @(negedge core_clk);
        prog_addr   = a;
        prog_data   = d;
        prog_we     = !rev;
        prog_rev_we = rev;
        @(negedge core_clk);
        prog_we     = 1'b0;
        prog_rev_we = 1'b0;
    endtask : prog

    task automatic start(input logic bm, input logic es, input logic [1:0] rs, input logic ci);
        @(negedge core_clk);
        i_cbs_fpga_model.cap_q.delete();
        i_cbs_fpga_model.bit_q.delete();
        byte_mode = bm;
        ext_sel   = es;
        rev_sel   = rs;
        clk_int   = ci;
        ce_b      = 1'b0;
        repeat (10) @(negedge core_clk);
    endtask : start

    task automatic stop();
        ce_b = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask : stop

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // pins ignored while loading
    task automatic t_prog();
        logic [7:0] img [7];
        img = '{8'hA5, 8'h03, 8'h5C, 8'hA5, 8'h00, 8'h11, 8'hC3};
        @(negedge core_clk);
        prog_active = 1'b1;
        ce_b        = 1'b0;
        for (int i = 0; i < 7; i++)
            prog(32'(i), img[i], 1'b0);
        prog(32'h0001_0000, 8'h3C, 1'b0);
        prog(32'h0, 8'h02, 1'b1);
        `CHK("cascade in prog", 1'b1, cascade_enable_out)
        `CHK("lanes in prog", 1'b1, byte_oe_b)
        stop();
        prog_active = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : t_prog

    task automatic t_byte();
        start(1'b1, 1'b1, 2'h0, 1'b0);
        `CHK("lanes on", 1'b0, byte_oe_b)
        i_cbs_fpga_model.pulses(5);
        for (int i = 0; i < 5; i++) `CHK("byte", exp_b[i], i_cbs_fpga_model.cap_q[i])
        stop();
    endtask : t_byte

    task automatic t_busy();
        start(1'b1, 1'b1, 2'h0, 1'b0);
        i_cbs_fpga_model.pulses(1);
        i_cbs_fpga_model.set_busy(1'b1);
        repeat (6) @(negedge core_clk);
        `CHK("lanes under busy", 1'b1, byte_oe_b)
        i_cbs_fpga_model.pulses(2);
        i_cbs_fpga_model.set_busy(1'b0);
        repeat (6) @(negedge core_clk);
        i_cbs_fpga_model.cap_q.delete();
        i_cbs_fpga_model.pulses(3);
        for (int i = 0; i < 3; i++) `CHK("byte after busy", exp_b[i+1], i_cbs_fpga_model.cap_q[i])
        stop();
    endtask : t_busy

    task automatic t_serial();
        trig = 1'b0;
        start(1'b0, 1'b1, 2'h0, 1'b0);
        `CHK("serial off, trigger low", 1'b1, serial_oe_b)
        trig = 1'b1;
        repeat (8) @(negedge core_clk);
        i_cbs_fpga_model.pulses(4);
        oe_rst = 1'b0;
        repeat (8) @(negedge core_clk);
        `CHK("serial off in reset", 1'b1, serial_oe_b)
        oe_rst = 1'b1;
        stop();
        start(1'b0, 1'b1, 2'h0, 1'b0);
        i_cbs_fpga_model.pulses(8);
        for (int i = 0; i < 8; i++) `CHK("bit", exp_b[0][7-i], i_cbs_fpga_model.bit_q[i])
        stop();
    endtask : t_serial

    // stored revision, then pin revision, own clock
    task automatic t_rev();
        logic found;
        for (int k = 0; k < 2; k++) begin
            // Stored bits pick revision 2 while pins say 1; then pins pick 2
            start(1'b1, k[0], k[0] ? 2'h2 : 2'h1, 1'b1);
            repeat (10) @(negedge core_clk);
            `CHK("clock driven", 1'b0, config_clock_oe_b)
            found = 1'b0;
            foreach (i_cbs_fpga_model.cap_q[i])
                if (i_cbs_fpga_model.cap_q[i] === 8'h3C)
                    found = 1'b1;
            `CHK("revision byte", 1'b1, found)
            stop();
        end
    endtask : t_rev

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        core_clk    = 1'b0;
        rst_b       = 1'b0;
        ce_b        = 1'b1;
        oe_rst      = 1'b1;
        trig        = 1'b1;
        ext_sel     = 1'b1;
        rev_sel     = 2'h0;
        byte_mode   = 1'b1;
        clk_int     = 1'b0;
        prog_active = 1'b0;
        prog_we     = 1'b0;
        prog_rev_we = 1'b0;
        prog_addr   = 32'h0;
        prog_data   = 8'h00;
        last_lanes  = 8'h00;
        last_bit    = 1'b0;
        n_mismatch  = 0;
        tests_run   = 0;
        exp_b       = '{8'h5C, 8'h5C, 8'h5C, 8'hA5, 8'h11};
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        `CHK("cascade after reset", 1'b0, cascade_enable_out)
        t_prog();
        t_byte();
        t_busy();
        t_serial();
        t_rev();
        print_verdict();
    end

    // Whole run is under five hundred cycles; this allows twenty thousand
    initial begin
        #1000000;
        n_mismatch++;
        print_verdict();
    end
endmodule : cbs_top_tb
